// File: dpf_pkg.sv
/*
  Shared constants for the DAC power and fault control link: frame layout,
  register select codes, power and control field positions, reset values,
  timing counts and the controller's own register map.
  Assumes a 100 MHz system clock on both ends.
*/
package dpf_pkg;
  // Serial frame layout, MSB first
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int RW_BIT = 23;
  localparam int SEL_MSB = 21;
  localparam int SEL_LSB = 19;
  localparam int ADR_MSB = 18;
  localparam int ADR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int HDR_LSB = 16;

  // Register select codes and control register addresses
  localparam logic [2:0] SEL_DAC = 3'h0;
  localparam logic [2:0] SEL_POWER = 3'h2;
  localparam logic [2:0] SEL_CONTROL = 3'h3;
  localparam logic [2:0] CTL_ADR_CONFIG = 3'h1;
  localparam logic [2:0] CTL_ADR_LOAD = 3'h5;

  // Power and fault status fields
  localparam int PWR_CHAN_LSB = 0;
  localparam int PWR_CHAN_MSB = 3;
  localparam int PWR_REF_BIT = 4;
  localparam int PWR_THERM_BIT = 5;
  localparam int PWR_ZERO_BIT = 6;
  localparam int PWR_OC_LSB = 7;
  localparam int PWR_OC_MSB = 10;

  // Control register fields at the configuration address
  localparam int CFG_SDO_DIS_BIT = 0;
  localparam int CFG_CLR_SEL_BIT = 1;
  localparam int CFG_CLAMP_BIT = 2;
  localparam int CFG_TSD_BIT = 3;

  // Reset values
  localparam logic [3:0] CHAN_POWER_RESET = 4'h0;
  localparam logic REF_POWER_RESET = 1'b0;
  localparam logic CLAMP_EN_RESET = 1'b1;
  localparam logic TSD_EN_RESET = 1'b0;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWER_UP_TIME_NS = 10000;
  localparam logic [9:0] POWER_UP_CYCLES =
    10'((POWER_UP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] SCLK_HALF_CYCLES = 4'h8;

  // Controller register map and bits
  localparam logic [7:0] HOST_REG_FRAME = 8'h00;
  localparam logic [7:0] HOST_REG_RXWORD = 8'h04;
  localparam logic [7:0] HOST_REG_STATUS = 8'h08;
  localparam logic [7:0] HOST_REG_MASK = 8'h0C;
  localparam logic [7:0] HOST_REG_CONFIG = 8'h10;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ALERT = 2;
  localparam int HCFG_EXT_REF_BIT = 0;

  typedef enum logic [2:0] {CTL_IDLE, CTL_HOLD, CTL_SETUP, CTL_LOW, CTL_HIGH, CTL_DONE} dpf_ctl_state_t;

  // Register select field of a frame
  function automatic logic [2:0] frameSel(input logic [23:0] word);
    frameSel = word[SEL_MSB:SEL_LSB];
  endfunction
endpackage

// File: dpf_link_if.sv
/*
  Serial link between the controller and the DAC power logic.
  Assumes the testbench instantiates it and joins both ends; the data-out
  pin is resolved here from its output enable, reading low when undriven.
*/
`timescale 1ns/1ps
`default_nettype none
interface dpf_link_if;
  logic sclk;
  logic syncN;
  logic sdin;
  logic sdo;
  logic sdoOe;
  logic sdoLine;

  // Undriven data-out reads as low
  assign sdoLine = sdoOe & sdo;

  modport dac_end (input sclk, input syncN, input sdin, output sdo, output sdoOe);
  modport ctl_end (output sclk, output syncN, output sdin, input sdoLine);
endinterface
`default_nettype wire

// File: dpf_dac_end.sv
/*
  DAC end: serial frame receiver, power and fault status register, control
  configuration bits, overcurrent and thermal responses and output gating.
  Assumes the link pins and the analog sense inputs are asynchronous to clk;
  all of them pass two flip-flops before use.
*/
// Function
// RULE1: Select code 010 reaches power register
// RULE2: Fixed bit layout of power register
// RULE3: Power-up bit enables channel, default off
// RULE4: Controller waits power-up time before load
// RULE5: Clamp off: overcurrent powers channel down
// RULE6: Overcurrent alert read-only, set on fault
// RULE7: Clamp on: channel stays up, alert live
// RULE8: Fault shown by alert; controller rewrites bit
// RULE9: Overtemperature powers down all, sets alert
// RULE10: Thermal shutdown off until enabled
// RULE11: Reference bit enables reference, default off
// RULE12: External reference: never set reference bit
// RULE13: Channels start powered down and clamped
// RULE14: Outputs clamped until supplies and data valid
// RULE15: Clamp enable defaults set
// RULE16: 24-bit frames captured on falling clock
// RULE17: Readback is live; alert writes ignored
`timescale 1ns/1ps
`default_nettype none
module dpf_dac_end
  import dpf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  dpf_link_if.dac_end link,
  input wire logic [3:0] overcurrentSense,
  input wire logic overTemp,
  input wire logic suppliesStable,
  output logic [3:0] channelPowered,
  output logic [3:0] outputReleased,
  output logic [3:0] currentLimiting,
  output logic referencePowered,
  output logic clearSelect
);
  import dpf_pkg::*;

  typedef struct packed {
    logic sclkS1;
    logic sclkS2;
    logic sclkPrev;
    logic syncS1;
    logic syncS2;
    logic syncPrev;
    logic dinS1;
    logic dinS2;
    logic [3:0] ocS1;
    logic [3:0] ocS2;
    logic hotS1;
    logic hotS2;
    logic supS1;
    logic supS2;
    logic [23:0] shiftIn;
    logic [4:0] bitCount;
    logic [23:0] shiftOut;
    logic [3:0] powerOn;
    logic refOn;
    logic sdoDisable;
    logic clrSel;
    logic clampEn;
    logic tsdEn;
    logic thermAlert;
    logic validWord;
    logic [3:0] released;
    logic [3:0] limiting;
  } dpf_dac_state_t;

  dpf_dac_state_t s;
  dpf_dac_state_t next_s;

  // Readback value of a selected register, built from live state
  function automatic logic [15:0] readValue(input logic [2:0] sel, input dpf_dac_state_t st);
    logic [15:0] v;
    v = 16'h0000;
    if (sel == SEL_POWER) begin
      v[PWR_OC_MSB:PWR_OC_LSB] = st.ocS2; // RULE6 RULE17
      v[PWR_ZERO_BIT] = 1'b0; // RULE2
      v[PWR_THERM_BIT] = st.thermAlert;
      v[PWR_REF_BIT] = st.refOn;
      v[PWR_CHAN_MSB:PWR_CHAN_LSB] = st.powerOn; // RULE2
    end else if (sel == SEL_CONTROL) begin
      v[CFG_TSD_BIT] = st.tsdEn;
      v[CFG_CLAMP_BIT] = st.clampEn;
      v[CFG_CLR_SEL_BIT] = st.clrSel;
      v[CFG_SDO_DIS_BIT] = st.sdoDisable;
    end
    readValue = v;
  endfunction

  // Next-state logic for the whole end
  always_comb begin
    logic fallEdge;
    logic riseEdge;
    logic frameEnd;
    logic frameStart;
    logic [23:0] word;
    logic [2:0] sel;
    logic [2:0] adr;
    logic [15:0] data;
    fallEdge = 1'b0;
    riseEdge = 1'b0;
    frameEnd = 1'b0;
    frameStart = 1'b0;
    word = s.shiftIn;
    sel = frameSel(s.shiftIn);
    adr = s.shiftIn[ADR_MSB:ADR_LSB];
    data = s.shiftIn[DATA_MSB:0];
    next_s = s;

    // Two-stage synchronisers; only the second stage feeds logic
    next_s.sclkS1 = link.sclk;
    next_s.sclkS2 = s.sclkS1;
    next_s.sclkPrev = s.sclkS2;
    next_s.syncS1 = link.syncN;
    next_s.syncS2 = s.syncS1;
    next_s.syncPrev = s.syncS2;
    next_s.dinS1 = link.sdin;
    next_s.dinS2 = s.dinS1;
    next_s.ocS1 = overcurrentSense;
    next_s.ocS2 = s.ocS1;
    next_s.hotS1 = overTemp;
    next_s.hotS2 = s.hotS1;
    next_s.supS1 = suppliesStable;
    next_s.supS2 = s.supS1;

    fallEdge = s.sclkPrev & ~s.sclkS2 & ~s.syncS2;
    riseEdge = ~s.sclkPrev & s.sclkS2 & ~s.syncS2;
    frameStart = s.syncPrev & ~s.syncS2;
    frameEnd = ~s.syncPrev & s.syncS2;

    // Shift in on the falling clock; count saturates so long frames are dropped
    if (frameStart) begin
      next_s.bitCount = 5'h00;
    end else if (fallEdge) begin
      next_s.shiftIn = {s.shiftIn[22:0], s.dinS2}; // RULE16
      if (s.bitCount != 5'h1F) begin
        next_s.bitCount = 5'(s.bitCount + 5'h01);
      end
    end

    // Readback data moves on the rising clock so the controller samples it at the end of the low phase, as the clock rises
    if (riseEdge) begin
      next_s.shiftOut = {s.shiftOut[22:0], 1'b0};
    end

    // Decode a complete frame when sync returns high
    if (frameEnd && s.bitCount == FRAME_BITS) begin // RULE16
      if (word[RW_BIT]) begin
        next_s.shiftOut = {word[23:HDR_LSB], readValue(sel, s)}; // RULE17
      end else if (sel == SEL_POWER) begin // RULE1
        // Alert bits in the written data are not stored
        next_s.powerOn = data[PWR_CHAN_MSB:PWR_CHAN_LSB]; // RULE3 RULE8 RULE17
        next_s.refOn = data[PWR_REF_BIT]; // RULE11
        if (!s.hotS2) begin
          next_s.thermAlert = 1'b0;
        end
      end else if (sel == SEL_CONTROL && adr == CTL_ADR_CONFIG) begin
        next_s.tsdEn = data[CFG_TSD_BIT]; // RULE10
        next_s.clampEn = data[CFG_CLAMP_BIT]; // RULE15
        next_s.clrSel = data[CFG_CLR_SEL_BIT];
        next_s.sdoDisable = data[CFG_SDO_DIS_BIT];
      end else if (sel == SEL_DAC && s.supS2) begin
        next_s.validWord = 1'b1; // RULE14
      end
    end

    // Automatic power-down beats a simultaneous write so a short cannot be re-armed
    for (int i = 0; i < 4; i++) begin
      if (!s.clampEn && s.ocS2[i]) begin
        next_s.powerOn[i] = 1'b0; // RULE5 RULE8
      end
      next_s.limiting[i] = s.clampEn & s.ocS2[i] & s.powerOn[i]; // RULE7
    end

    // Thermal shutdown acts only once enabled; set wins over the clear above
    if (s.tsdEn && s.hotS2) begin // RULE10
      next_s.powerOn = CHAN_POWER_RESET; // RULE9
      next_s.thermAlert = 1'b1; // RULE9
    end

    // Losing the supplies invalidates the data and clamps every output again
    if (!s.supS2) begin
      next_s.validWord = 1'b0; // RULE14
    end

    // Output released only when powered, supplies stable and a word written
    next_s.released = s.powerOn & {4{s.validWord & s.supS2}}; // RULE13 RULE14
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.sclkS1 <= 1'b1;
      s.sclkS2 <= 1'b1;
      s.sclkPrev <= 1'b1;
      s.syncS1 <= 1'b1;
      s.syncS2 <= 1'b1;
      s.syncPrev <= 1'b1;
      s.powerOn <= CHAN_POWER_RESET; // RULE3 RULE13
      s.refOn <= REF_POWER_RESET; // RULE11
      s.clampEn <= CLAMP_EN_RESET; // RULE15
      s.tsdEn <= TSD_EN_RESET; // RULE10
    end else begin
      s <= next_s;
    end
  end

  // Pin and user outputs straight from flip-flops, except the data-out enable, which is the AND of two of them
  assign link.sdo = s.shiftOut[23];
  assign link.sdoOe = ~s.syncS2 & ~s.sdoDisable;
  assign channelPowered = s.powerOn;
  assign outputReleased = s.released;
  assign currentLimiting = s.limiting;
  assign referencePowered = s.refOn;
  assign clearSelect = s.clrSel;
endmodule
`default_nettype wire

// File: dpf_ctl_end.sv
/*
  Controller end: sends 24-bit frames ordered through its register port,
  captures readback, holds load commands for the channel power-up time and
  keeps the internal reference off in external reference mode.
  Assumes a single-cycle register master on clk; the data-out pin is
  asynchronous and passes two flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none
module dpf_ctl_end
  import dpf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  dpf_link_if.ctl_end link,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic irq
);
  import dpf_pkg::*;

  typedef struct packed {
    dpf_ctl_state_t fsm;
    logic [3:0] div;
    logic [4:0] bitIdx;
    logic [23:0] txWord;
    logic [23:0] sentWord;
    logic [23:0] rxShift;
    logic [23:0] rxWord;
    logic sdoS1;
    logic sdoS2;
    logic done;
    logic alert;
    logic [2:0] mask;
    logic extRef;
    logic armTimer;
    logic [9:0] puTimer;
    logic [31:0] rdata;
    logic sclk;
    logic syncN;
  } dpf_ctl_reg_t;

  dpf_ctl_reg_t s;
  dpf_ctl_reg_t next_s;

  always_comb begin
    logic [23:0] w;
    logic phaseEnd;
    logic [2:0] stat;
    w = regWdata[23:0];
    phaseEnd = (s.div == 4'(SCLK_HALF_CYCLES - 4'h1));
    stat = {s.alert, s.done, (s.fsm != CTL_IDLE)};
    next_s = s;
    next_s.sdoS1 = link.sdoLine;
    next_s.sdoS2 = s.sdoS1;
    next_s.div = phaseEnd ? 4'h0 : 4'(s.div + 4'h1);
    if (s.puTimer != 10'h000) begin
      next_s.puTimer = 10'(s.puTimer - 10'h001);
    end

    // Register writes; sticky bits clear on writing one
    if (regWrite) begin
      if (regAddr == HOST_REG_STATUS) begin
        next_s.done = s.done & ~regWdata[ST_DONE];
        next_s.alert = s.alert & ~regWdata[ST_ALERT];
      end else if (regAddr == HOST_REG_MASK) begin
        next_s.mask = regWdata[2:0];
      end else if (regAddr == HOST_REG_CONFIG) begin
        next_s.extRef = regWdata[HCFG_EXT_REF_BIT];
      end else if (regAddr == HOST_REG_FRAME && s.fsm == CTL_IDLE) begin
        if (s.extRef && frameSel(w) == SEL_POWER) begin
          w[PWR_REF_BIT] = 1'b0; // RULE12
        end
        next_s.txWord = w;
        next_s.sentWord = w;
        next_s.armTimer = !w[RW_BIT] && frameSel(w) == SEL_POWER
          && w[PWR_CHAN_MSB:PWR_CHAN_LSB] != 4'h0;
        next_s.div = 4'h0;
        next_s.bitIdx = 5'h00;
        // A load waits out the power-up time of a freshly enabled channel
        if (frameSel(w) == SEL_CONTROL && w[ADR_MSB:ADR_LSB] == CTL_ADR_LOAD
            && s.puTimer != 10'h000) begin
          next_s.fsm = CTL_HOLD; // RULE4
        end else begin
          next_s.fsm = CTL_SETUP;
        end
      end
    end

    // Frame sequencer: data changes on rising clock, device captures on falling
    case (s.fsm)
      CTL_IDLE: begin
        next_s.syncN = 1'b1;
        next_s.sclk = 1'b1;
      end
      CTL_HOLD: begin
        if (s.puTimer == 10'h000) begin
          next_s.fsm = CTL_SETUP;
          next_s.div = 4'h0;
        end
      end
      CTL_SETUP: begin
        next_s.syncN = 1'b0;
        if (phaseEnd) begin
          next_s.fsm = CTL_LOW;
          next_s.sclk = 1'b0; // RULE16
        end
      end
      CTL_LOW: begin
        if (phaseEnd) begin
          next_s.rxShift = {s.rxShift[22:0], s.sdoS2};
          next_s.sclk = 1'b1;
          next_s.bitIdx = 5'(s.bitIdx + 5'h01);
          if (5'(s.bitIdx + 5'h01) == FRAME_BITS) begin // RULE16
            next_s.fsm = CTL_DONE;
          end else begin
            next_s.txWord = {s.txWord[22:0], 1'b0};
            next_s.fsm = CTL_HIGH;
          end
        end
      end
      CTL_HIGH: begin
        if (phaseEnd) begin
          next_s.fsm = CTL_LOW;
          next_s.sclk = 1'b0;
        end
      end
      CTL_DONE: begin
        if (phaseEnd) begin
          next_s.syncN = 1'b1;
          next_s.fsm = CTL_IDLE;
          next_s.rxWord = s.rxShift;
          next_s.done = 1'b1;
          // Readback of the power register showing a fault; software rewrites to restore
          if (frameSel(s.rxShift) == SEL_POWER
              && (s.rxShift[PWR_OC_MSB:PWR_OC_LSB] != 4'h0 || s.rxShift[PWR_THERM_BIT])) begin
            next_s.alert = 1'b1; // RULE8
          end
          if (s.armTimer) begin
            next_s.puTimer = POWER_UP_CYCLES; // RULE4
          end
        end
      end
      default: next_s.fsm = CTL_IDLE;
    endcase

    // Read data stands in the cycle after the strobe
    next_s.rdata = 32'h0000_0000;
    if (regRead) begin
      if (regAddr == HOST_REG_FRAME) begin
        next_s.rdata = {8'h00, s.sentWord};
      end else if (regAddr == HOST_REG_RXWORD) begin
        next_s.rdata = {8'h00, s.rxWord};
      end else if (regAddr == HOST_REG_STATUS) begin
        next_s.rdata = {29'h0000_0000, stat};
      end else if (regAddr == HOST_REG_MASK) begin
        next_s.rdata = {29'h0000_0000, s.mask};
      end else if (regAddr == HOST_REG_CONFIG) begin
        next_s.rdata = {31'h0000_0000, s.extRef};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.fsm <= CTL_IDLE;
      s.sclk <= 1'b1;
      s.syncN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.sclk = s.sclk;
  assign link.syncN = s.syncN;
  assign link.sdin = s.txWord[23];
  assign regRdata = s.rdata;
  // Level interrupt while any unmasked sticky bit is set
  assign irq = |({s.alert, s.done} & s.mask[2:1]);
endmodule
`default_nettype wire

// File: dpf_link_monitor.sv
/*
  Checker for the DAC power link: frame shape on the wire and the power
  outputs of the DAC end.
  Assumes the bench instantiates it beside the link on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dpf_link_monitor
  import dpf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic syncN,
  input wire logic sdin,
  input wire logic [3:0] channelPowered,
  input wire logic [3:0] outputReleased,
  input wire logic [3:0] currentLimiting,
  input wire logic referencePowered
);
  import dpf_pkg::*;

  typedef struct packed {
    logic sclkQ;
    logic [4:0] falls;
  } dpf_mon_state_t;
  dpf_mon_state_t st;
  dpf_mon_state_t next_st;

  // Count serial clock falls inside a frame; cleared while the frame is idle
  always_comb begin
    next_st = st;
    next_st.sclkQ = sclk;
    if (syncN) next_st.falls = 5'h00;
    else if (st.sclkQ && !sclk) next_st.falls = st.falls + 5'h01;
  end

  always_ff @(posedge clk) begin
    if (reset) st <= '0;
    else st <= next_st;
  end

  default clocking mcb @(posedge clk); endclocking
  default disable iff (reset);

  sequence frameStart; $fell(syncN); endsequence
  sequence frameEnd; ##[300:1000] $rose(syncN); endsequence
  sequence lowPhase; $fell(sclk) ##1 (!sclk)[*7]; endsequence

  idle_clock_high_a: assert property (syncN |-> sclk)
    else $error("serial clock low outside a frame");
  half_period_a: assert property ($fell(sclk) |-> lowPhase)
    else $error("serial clock low phase too short");
  data_hold_a: assert property ($fell(sclk) |-> $stable(sdin) [*8])
    else $error("data moved while serial clock low");
  bit_count_a: assert property ($rose(syncN) |-> st.falls == FRAME_BITS)
    else $error("frame without the full bit count");
  frame_span_a: assert property (frameStart |-> frameEnd)
    else $error("frame length out of range");
  reset_power_a: assert property ($fell(reset) |-> channelPowered == 4'h0
    && !referencePowered && outputReleased == 4'h0) else $error("powered after reset");
  limit_powered_a: assert property ((currentLimiting
    & ~(channelPowered | $past(channelPowered))) == 4'h0) else $error("limit on dead channel");
  release_powered_a: assert property ((outputReleased
    & ~(channelPowered | $past(channelPowered))) == 4'h0) else $error("output released unpowered");
endmodule
`default_nettype wire

// File: dac_power_fault_control_tb_top.sv
/*
  Testbench joining the controller and DAC ends over the link; drives the
  register port and the analog sense inputs and checks the power outputs.
  Assumes the package constants and the hand-over register map.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_power_fault_control_tb_top;
  import dpf_pkg::*;
  logic clk, reset, regWrite, regRead, overTemp, suppliesStable, referencePowered;
  logic clearSelect, irq;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [3:0] overcurrentSense, channelPowered, outputReleased, currentLimiting;
  int fails, compares, waits, i;
  // Power writes beside the readback they should give; alert bits are not writable
  logic [15:0] rowIn [5] = '{16'h000F, 16'h0005, 16'h001A, 16'hFFE0, 16'h0000};
  logic [15:0] rowOut [5] = '{16'h000F, 16'h0005, 16'h001A, 16'h0000, 16'h0000};

  dpf_link_if link ();
  dpf_dac_end i_dpf_dac_end (.clk(clk), .reset(reset), .link(link),
    .overcurrentSense(overcurrentSense), .overTemp(overTemp),
    .suppliesStable(suppliesStable), .channelPowered(channelPowered),
    .outputReleased(outputReleased), .currentLimiting(currentLimiting),
    .referencePowered(referencePowered), .clearSelect(clearSelect));
  dpf_ctl_end i_dpf_ctl_end (.clk(clk), .reset(reset), .link(link), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .irq(irq));
  dpf_link_monitor i_dpf_link_monitor (.clk(clk), .reset(reset), .sclk(link.sclk),
    .syncN(link.syncN), .sdin(link.sdin), .channelPowered(channelPowered),
    .outputReleased(outputReleased), .currentLimiting(currentLimiting),
    .referencePowered(referencePowered));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Mismatches %0d, compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One-cycle strobes with a gap, so no strobe is assigned twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
    @(posedge clk);
  endtask

  // Send a frame and poll busy; waits keeps the poll count for timing checks
  task automatic frame(input logic [23:0] w);
    wr(HOST_REG_FRAME, {8'h00, w});
    for (waits = 0; waits < 3000; waits++) begin
      rd(HOST_REG_STATUS);
      if (d[ST_BUSY] === 1'b0) break;
    end
    if (waits == 3000) begin
      fails++;
      finish_test();
    end
    wr(HOST_REG_STATUS, 32'h0000_0002);
  endtask

  task automatic readPower(input logic [15:0] exp);
    frame(24'h900000);
    frame(24'h180000);
    rd(HOST_REG_RXWORD);
    chk("readback", d, {16'h0090, exp});
  endtask

  initial begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    overcurrentSense = 4'h0;
    overTemp = 1'b0;
    suppliesStable = 1'b0;
    fails = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    chk("chan", channelPowered, 4'h0);
    chk("ref", referencePowered, 1'b0);
    chk("irq", irq, 1'b0);
    rd(8'h40);
    chk("unmapped", d, 32'h0);
    for (i = 0; i < 5; i++) begin
      frame({8'h10, rowIn[i]});
      repeat (8) @(posedge clk);
      chk("chan", channelPowered, rowOut[i][3:0]);
      chk("ref", referencePowered, rowOut[i][4]);
      readPower(rowOut[i]);
    end
    // Another select code must leave power alone
    frame(24'h08000F);
    repeat (8) @(posedge clk);
    chk("select", channelPowered, 4'h0);
    // A load right after power-up is held back by the controller
    frame(24'h10000F);
    frame(24'h1D0000);
    chk("hold", waits * 2 > POWER_UP_CYCLES, 1'b1);
    // Outputs stay clamped until supplies are good and a word is written
    frame(24'h000123);
    repeat (8) @(posedge clk);
    chk("gate", outputReleased, 4'h0);
    suppliesStable <= 1'b1;
    repeat (8) @(posedge clk);
    chk("gate", outputReleased, 4'h0);
    frame(24'h000123);
    repeat (8) @(posedge clk);
    chk("gate", outputReleased, 4'hF);
    // Short with clamp at its default: channel stays up, alert live
    wr(HOST_REG_MASK, 32'h4);
    overcurrentSense <= 4'h2;
    repeat (8) @(posedge clk);
    chk("limit", currentLimiting, 4'h2);
    chk("chan", channelPowered, 4'hF);
    readPower(16'h010F);
    chk("irq", irq, 1'b1);
    overcurrentSense <= 4'h0;
    repeat (8) @(posedge clk);
    readPower(16'h000F);
    wr(HOST_REG_MASK, 32'h0);
    chk("irq", irq, 1'b0);
    wr(HOST_REG_STATUS, 32'h4);
    wr(HOST_REG_MASK, 32'h4);
    chk("irq", irq, 1'b0);
    // Clamp off: the shorted channel powers down until rewritten
    frame(24'h190000);
    overcurrentSense <= 4'h4;
    repeat (8) @(posedge clk);
    chk("chan", channelPowered, 4'hB);
    readPower(16'h020B);
    overcurrentSense <= 4'h0;
    repeat (8) @(posedge clk);
    frame(24'h10000F);
    repeat (8) @(posedge clk);
    chk("chan", channelPowered, 4'hF);
    // Heat is ignored until shutdown is enabled
    overTemp <= 1'b1;
    repeat (8) @(posedge clk);
    chk("chan", channelPowered, 4'hF);
    // Shutdown enable together with the clear-select bit, so that output is seen set
    frame(24'h19000A);
    repeat (8) @(posedge clk);
    chk("chan", channelPowered, 4'h0);
    chk("gate", outputReleased, 4'h0);
    chk("clear", clearSelect, 1'b1);
    readPower(16'h0020);
    overTemp <= 1'b0;
    // External reference mode keeps the on-chip reference off
    wr(HOST_REG_CONFIG, 32'h1);
    frame(24'h10001F);
    repeat (8) @(posedge clk);
    chk("ref", referencePowered, 1'b0);
    chk("chan", channelPowered, 4'hF);
    // Data-out disabled: the released line reads low, so the captured word is empty
    frame(24'h190001);
    frame(24'h900000);
    frame(24'h180000);
    rd(HOST_REG_RXWORD);
    chk("sdo off", d, 32'h0);
    // Reset in mid-run drops everything back to power-down
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk("chan", channelPowered, 4'h0);
    chk("ref", referencePowered, 1'b0);
    chk("irq", irq, 1'b0);
    chk("clear", clearSelect, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
